/* verilog/panel_pkg.sv */
// constants, field layouts and carriers for the local control panel
package panel_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 250;
    localparam int DEBOUNCE_US = 10000;
    localparam int DEBOUNCE_CNT = DEBOUNCE_US * CLK_MHZ;
    localparam int DB_CNT_W = 22;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_ACCESS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_RMM_MODE = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 12'h00C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;

    // cfg fields
    localparam int CFG_INTERLOCK_BIT = 0;
    localparam int CFG_SHUTDOWN_BIT = 1;
    localparam logic [1:0] CFG_RST = 2'h0;

    // access fields
    localparam int ACC_LOCAL_LSB = 0;
    localparam int ACC_REMOTE_LSB = 2;
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [1:0] LVL_3 = 2'h3;

    // rmm mode field
    localparam int MODE_MANUAL_BIT = 0;

    // limit register
    localparam int LIMIT_W = 16;
    localparam logic [LIMIT_W-1:0] LIMIT_RST = 16'h0000;

    // status fields
    localparam int ST_ON_BIT = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int ST_MAIN_BIT = 2;
    localparam int ST_MANUAL_BIT = 3;
    localparam int ST_INTERLOCK_BIT = 4;
    localparam int ST_BATT_DISC_BIT = 5;
    localparam int ST_LGRANT_LSB = 6;
    localparam int ST_RGRANT_LSB = 8;
    localparam int ST_LEDS_LSB = 10;

    // ****************************************
    // debounced panel inputs
    // ****************************************
    localparam int IN_ONOFF = 0;
    localparam int IN_SWAP = 1;
    localparam int IN_MAIN_SEL = 2;
    localparam int IN_REM_ONOFF = 3;
    localparam int IN_REM_SWAP = 4;
    localparam int IN_REMOTE_SW = 5;
    localparam int IN_MANUAL_SW = 6;
    localparam int IN_INTERLOCK = 7;
    localparam int IN_WPROT = 8;
    localparam int N_DB = 9;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] mon1_alarm;
        logic [7:0] mon2_alarm;
        logic mon1_warn;
        logic mon2_warn;
        logic maint_fault;
        logic rms_warning;
        logic batt_low;
        logic mains_ok;
        logic wp_strap;
    } status_pins_t;

    typedef struct packed {
        logic service;
        logic alarm;
        logic normal;
        logic warning;
        logic param_warn;
        logic disagree;
        logic batt_warn;
        logic maint_warn;
        logic standby_air;
    } leds_t;

    localparam int LEDS_W = $bits(leds_t);

endpackage : panel_pkg

/* verilog/debouncer.sv */
// two-flop synchroniser, debounce filter and rising-edge pulse for one input
`timescale 1ns/100ps
module debouncer import panel_pkg::*; #(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CNT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // raw pin and filtered result
    input wire logic raw_i,
    output logic level_o,
    output logic rise_o
);

    logic meta_r;
    logic sync_r;
    logic [DB_CNT_W-1:0] cnt_r;
    wire logic differs = sync_r != level_o;
    wire logic settled = cnt_r == DB_CNT_W'(DEBOUNCE_CYCLES - 1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            cnt_r <= '0;
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta_r <= raw_i;
            sync_r <= meta_r;
            cnt_r <= (differs && !settled) ? cnt_r + 1'b1 : '0;
            level_o <= (differs && settled) ? sync_r : level_o;
            rise_o <= differs && settled && sync_r; // R22
        end
    end

endmodule : debouncer

/* verilog/beacon_local_control_panel.sv */
// front-panel control logic of a dual-transmitter beacon cabinet, with apb registers
//
// How it works
// R1 - local on/off press toggles beacon, local mode only, blocked by configured interlock
// R2 - local swap press changes active transmitter; local only; auto needs beacon on
// R3 - main-select press swaps main and standby designation, local mode only
// R4 - remote mode ignores local buttons and denies levels two and three locally
// R5 - local mode ignores remote buttons and blocks the remote serial port
// R6 - manual/auto switch sets the mode only in local position
// R7 - in auto, a new alarm causes active_tx_swap_button or shutdown as configured
// R8 - in manual, alarms leave the transmitter state untouched
// R9 - active interlock forces transmitters off until it clears, overriding manual
// R10 - write protect rejects limit writes and denies access level three
// R11 - in remote mode the maintenance program may set manual or auto
// R12 - service lights on remote access, local, manual, remote manual or strap mismatch
// R13 - service also raises the alarm toward the remote control unit
// R14 - alarm lights with any alarm; normal lights only with none
// R15 - parameter warning lights from the voted monitor warnings
// R16 - monitor disagree lights when the two alarm sets differ
// R17 - battery warning lights while mains for charging is lost
// R18 - maintenance warning lights on a faulty maintenance parameter
// R19 - standby-on-air lights when the antenna transmitter is not the main one
// R20 - general warning lights when the remote monitor system reports a warning
// R21 - battery disconnects below cutoff and stays off until mains returns
// R22 - each button is synchronised, debounced and acts once per press
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
module beacon_local_control_panel import panel_pkg::*; #(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CNT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // front-panel buttons and switches
    input wire logic btn_onoff_i,
    input wire logic active_tx_swap_button_i,
    input wire logic btn_main_sel_i,
    input wire logic remote_sw_i,
    input wire logic manual_sw_i,
    input wire logic interlock_i,
    input wire logic write_protect_i,
    // remote control unit buttons
    input wire logic remote_onoff_i,
    input wire logic remote_swap_i,
    // monitor, maintenance and power status pins
    input wire status_pins_t status_i,
    // transmitter control
    output logic beacon_on_o,
    output logic first_transmitter_on_o,
    output logic second_transmitter_on_o,
    output logic antenna_second_o,
    output logic main_is_second_o,
    // power and remote alarm
    output logic battery_disconnect_o,
    output logic remote_alarm_o,
    // indicators
    output leds_t leds_o
);

    // ****************************************
    // input conditioning
    // ****************************************
    logic [N_DB-1:0] db_level;
    logic [N_DB-1:0] db_rise;
    wire logic [N_DB-1:0] raw_in = {
        write_protect_i,
        interlock_i,
        manual_sw_i,
        remote_sw_i,
        remote_swap_i,
        remote_onoff_i,
        btn_main_sel_i,
        active_tx_swap_button_i,
        btn_onoff_i
    };

    for (genvar gi = 0; gi < N_DB; gi++) begin : g_db
        debouncer #(
            .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
        ) u_db (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .raw_i(raw_in[gi]),
            .level_o(db_level[gi]),
            .rise_o(db_rise[gi])
        );
    end

    // status pins are levels from another domain: plain two-flop sync
    status_pins_t st_meta_r;
    status_pins_t st_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_meta_r <= '0;
            st_r <= '0;
        end else begin
            st_meta_r <= status_i;
            st_r <= st_meta_r;
        end
    end

    // ****************************************
    // state registers
    // ****************************************
    logic on_r;
    logic active_r;
    logic main_r;
    logic manual_r;
    logic rmm_manual_r;
    logic batt_disc_r;
    logic alarm_seen_r;
    logic [1:0] cfg_r;
    logic [3:0] access_r;
    logic [LIMIT_W-1:0] limit_r;
    logic [1:0] lgrant_r;
    logic [1:0] rgrant_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // ****************************************
    // mode qualification
    // ****************************************
    wire logic remote_mode = db_level[IN_REMOTE_SW];
    wire logic local_mode = !remote_mode;
    wire logic wprot = db_level[IN_WPROT];
    wire logic interlock_act = cfg_r[CFG_INTERLOCK_BIT] && db_level[IN_INTERLOCK];
    wire logic shutdown_cfg = cfg_r[CFG_SHUTDOWN_BIT];

    wire logic local_onoff = db_rise[IN_ONOFF] && local_mode; // R4
    wire logic local_swap = db_rise[IN_SWAP] && local_mode; // R4
    wire logic local_main = db_rise[IN_MAIN_SEL] && local_mode; // R3
    wire logic rem_onoff = db_rise[IN_REM_ONOFF] && remote_mode; // R5
    wire logic rem_swap = db_rise[IN_REM_SWAP] && remote_mode; // R5

    wire logic onoff_go = (local_onoff || rem_onoff) && !interlock_act; // R1
    wire logic swap_go = (local_swap || rem_swap) && (manual_r || on_r); // R2

    // alarms taken from both monitors
    wire logic [7:0] alarm_union = st_r.mon1_alarm | st_r.mon2_alarm;
    wire logic alarm_any = |alarm_union;
    // only a fresh alarm acts, so a standing one cannot keep swapping
    wire logic alarm_new = alarm_any && !alarm_seen_r;
    wire logic auto_hit = !manual_r && alarm_new && on_r; // R7 R8

    // ****************************************
    // next state
    // ****************************************
    logic on_nxt;
    logic active_nxt;
    logic main_nxt;
    logic manual_nxt;
    logic rmm_manual_nxt;

    assign on_nxt = interlock_act ? 1'b0 : // R9
                    onoff_go ? !on_r : // R1
                    (auto_hit && shutdown_cfg) ? 1'b0 : on_r; // R7
    assign active_nxt = ((swap_go || (auto_hit && !shutdown_cfg)) && !interlock_act) ? !active_r : active_r; // R2 R7
    assign main_nxt = local_main ? !main_r : main_r; // R3

    // ****************************************
    // apb decode
    // ****************************************
    wire logic apb_setup = psel_i && !penable_i;
    wire logic apb_done = psel_i && penable_i && pready_r;
    wire logic hit_cfg = paddr_i == ADDR_CFG;
    wire logic hit_access = paddr_i == ADDR_ACCESS;
    wire logic hit_mode = paddr_i == ADDR_RMM_MODE;
    wire logic hit_limit = paddr_i == ADDR_LIMIT;
    wire logic hit_status = paddr_i == ADDR_STATUS;
    wire logic hit_any = hit_cfg || hit_access || hit_mode || hit_limit || hit_status;

    wire logic limit_refused = hit_limit && wprot; // R10
    wire logic mode_refused = hit_mode && local_mode; // R5
    wire logic wr_refused = pwrite_i && (limit_refused || mode_refused || hit_status);
    wire logic access_err = !hit_any || wr_refused;

    wire logic wr_ok = apb_done && pwrite_i && !pslverr_r;
    wire logic wr_cfg = wr_ok && hit_cfg;
    wire logic wr_access = wr_ok && hit_access;
    wire logic wr_mode = wr_ok && hit_mode && remote_mode; // R11
    wire logic wr_limit = wr_ok && hit_limit && !wprot; // R10

    assign manual_nxt = local_mode ? db_level[IN_MANUAL_SW] : // R6
                        wr_mode ? pwdata_i[MODE_MANUAL_BIT] : manual_r; // R11
    assign rmm_manual_nxt = local_mode ? 1'b0 :
                            wr_mode ? pwdata_i[MODE_MANUAL_BIT] : rmm_manual_r;

    // ****************************************
    // access levels
    // ****************************************
    function automatic logic [1:0] grant_level(
        input logic [1:0] req,
        input logic high_ok,
        input logic wp
    );
        logic [1:0] lvl;
        lvl = req;
        if (req >= LVL_2 && !high_ok) begin
            lvl = LVL_1;
        end else if (req == LVL_3 && wp) begin
            lvl = LVL_2;
        end
        return lvl;
    endfunction : grant_level

    wire logic [1:0] lreq = access_r[ACC_LOCAL_LSB +: 2];
    wire logic [1:0] rreq = access_r[ACC_REMOTE_LSB +: 2];
    wire logic [1:0] lgrant_nxt = grant_level(lreq, local_mode, wprot); // R4 R10
    wire logic [1:0] rgrant_nxt = local_mode ? LVL_0 : grant_level(rreq, 1'b1, wprot); // R5 R10

    // ****************************************
    // indicators
    // ****************************************
    wire logic high_access = rgrant_r >= LVL_2 || lgrant_r >= LVL_2;
    wire logic strap_mismatch = wprot != st_r.wp_strap;
    leds_t leds_nxt;

    assign leds_nxt.service = high_access || local_mode || db_level[IN_MANUAL_SW] ||
                              rmm_manual_r || strap_mismatch; // R12
    assign leds_nxt.alarm = alarm_any; // R14
    assign leds_nxt.normal = !alarm_any; // R14
    assign leds_nxt.warning = st_r.rms_warning; // R20
    // two-out-of-two vote: one noisy monitor alone does not light it
    assign leds_nxt.param_warn = st_r.mon1_warn && st_r.mon2_warn; // R15
    assign leds_nxt.disagree = st_r.mon1_alarm != st_r.mon2_alarm; // R16
    assign leds_nxt.batt_warn = !st_r.mains_ok; // R17
    assign leds_nxt.maint_warn = st_r.maint_fault; // R18
    assign leds_nxt.standby_air = active_r != main_r; // R19

    // mains return reconnects even if the cell is still low, so it can charge
    wire logic batt_disc_nxt = st_r.mains_ok ? 1'b0 : // R21
                               st_r.batt_low ? 1'b1 : batt_disc_r; // R21

    // ****************************************
    // read mux
    // ****************************************
    logic [31:0] status_word;
    logic [31:0] rd_word;

    always_comb begin
        status_word = '0;
        status_word[ST_ON_BIT] = on_r;
        status_word[ST_ACTIVE_BIT] = active_r;
        status_word[ST_MAIN_BIT] = main_r;
        status_word[ST_MANUAL_BIT] = manual_r;
        status_word[ST_INTERLOCK_BIT] = interlock_act;
        status_word[ST_BATT_DISC_BIT] = batt_disc_r;
        status_word[ST_LGRANT_LSB +: 2] = lgrant_r;
        status_word[ST_RGRANT_LSB +: 2] = rgrant_r;
        status_word[ST_LEDS_LSB +: LEDS_W] = leds_o;
    end

    assign rd_word = hit_cfg ? {30'h0000_0000, cfg_r} :
                     hit_access ? {28'h000_0000, access_r} :
                     hit_mode ? {31'h0000_0000, manual_r} :
                     hit_limit ? {16'h0000, limit_r} :
                     hit_status ? status_word : 32'h0000_0000;

    // ****************************************
    // apb registers
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup && access_err;
            prdata_r <= (apb_setup && !pwrite_i) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r <= CFG_RST;
            access_r <= ACC_RST;
            limit_r <= LIMIT_RST;
        end else begin
            cfg_r <= wr_cfg ? pwdata_i[1:0] : cfg_r;
            access_r <= wr_access ? pwdata_i[3:0] : access_r;
            limit_r <= wr_limit ? pwdata_i[LIMIT_W-1:0] : limit_r; // R10
        end
    end

    // ****************************************
    // control state
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_r <= 1'b0;
            active_r <= 1'b0;
            main_r <= 1'b0;
            manual_r <= 1'b0;
            rmm_manual_r <= 1'b0;
            alarm_seen_r <= 1'b0;
            batt_disc_r <= 1'b0;
            lgrant_r <= LVL_0;
            rgrant_r <= LVL_0;
        end else begin
            on_r <= on_nxt;
            active_r <= active_nxt;
            main_r <= main_nxt;
            manual_r <= manual_nxt;
            rmm_manual_r <= rmm_manual_nxt;
            alarm_seen_r <= alarm_any;
            batt_disc_r <= batt_disc_nxt;
            lgrant_r <= lgrant_nxt;
            rgrant_r <= rgrant_nxt;
        end
    end

    // ****************************************
    // output flops
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            beacon_on_o <= 1'b0;
            first_transmitter_on_o <= 1'b0;
            second_transmitter_on_o <= 1'b0;
            antenna_second_o <= 1'b0;
            main_is_second_o <= 1'b0;
            battery_disconnect_o <= 1'b0;
            remote_alarm_o <= 1'b0;
            leds_o <= '0;
        end else begin
            beacon_on_o <= on_nxt;
            first_transmitter_on_o <= on_nxt && !active_nxt; // R9
            second_transmitter_on_o <= on_nxt && active_nxt; // R9
            antenna_second_o <= active_nxt;
            main_is_second_o <= main_nxt;
            battery_disconnect_o <= batt_disc_nxt; // R21
            remote_alarm_o <= leds_nxt.alarm || leds_nxt.service; // R13
            leds_o <= leds_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;

endmodule : beacon_local_control_panel

/* tb/panel_asserts.sv */
// concurrent checks on the outputs of the local control panel
`timescale 1ns/100ps
module panel_asserts import panel_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // status pins
    input wire status_pins_t status_i,
    // transmitter, power and lamps
    input wire logic beacon_on_o,
    input wire logic first_transmitter_on_o,
    input wire logic second_transmitter_on_o,
    input wire logic antenna_second_o,
    input wire logic main_is_second_o,
    input wire logic battery_disconnect_o,
    input wire logic remote_alarm_o,
    input wire leds_t leds_o
);
    // ****************************************
    // checks
    // ****************************************
    // pins pass two sync flops and one register, so four stable cycles settle a lamp
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_lamp_pair: assert property ($past(rst_n_i) |-> leds_o.normal != leds_o.alarm)
        else $error("normal and alarm lamps agree");
    chk_remote_alarm: assert property (leds_o.service || leds_o.alarm |-> ##[0:1] remote_alarm_o)
        else $error("remote alarm missing");
    chk_tx_excl: assert property (first_transmitter_on_o |-> beacon_on_o && !second_transmitter_on_o)
        else $error("transmitter enables inconsistent");
    chk_stby_air: assert property ((antenna_second_o != main_is_second_o)[*3] |-> leds_o.standby_air)
        else $error("standby on air lamp dark");
    chk_mon_disagree: assert property ((status_i.mon1_alarm != status_i.mon2_alarm)[*4] |-> leds_o.disagree)
        else $error("disagree lamp dark");
    chk_param_warn: assert property ((status_i.mon1_warn && status_i.mon2_warn)[*4] |-> leds_o.param_warn)
        else $error("parameter warning lamp dark");
    chk_param_vote: assert property ((!status_i.mon1_warn)[*4] |-> !leds_o.param_warn)
        else $error("parameter warning without vote");
    chk_batt_warn: assert property ((!status_i.mains_ok)[*4] |-> leds_o.batt_warn)
        else $error("battery warning lamp dark");
    chk_rms_warn: assert property (status_i.rms_warning[*4] |-> leds_o.warning)
        else $error("warning lamp dark");
    chk_batt_cut: assert property ((status_i.batt_low && !status_i.mains_ok)[*4] |-> battery_disconnect_o)
        else $error("battery not disconnected");
    chk_batt_clear: assert property (status_i.mains_ok[*4] |-> !battery_disconnect_o)
        else $error("battery kept off with mains");
endmodule : panel_asserts

/* tb/panel_model.sv */
// operator panel and remote control unit: buttons and switches
`timescale 1ns/100ps
module panel_model import panel_pkg::*; #(
    parameter int HOLD = 16
) (
    // clock
    input wire logic clk_i,
    // pins indexed as the debounced inputs
    output logic [N_DB-1:0] pins_o
);
    // ****************************************
    // operator actions
    // ****************************************
    initial pins_o = '0;

    // held well past the filter, then released as long: one clean press
    task automatic press(input int idx);
        pins_o[idx] <= 1'b1;
        repeat (HOLD) @(posedge clk_i);
        pins_o[idx] <= 1'b0;
        repeat (HOLD) @(posedge clk_i);
    endtask : press

    task automatic set_sw(input int idx, input logic v);
        pins_o[idx] <= v;
        repeat (HOLD) @(posedge clk_i);
    endtask : set_sw
endmodule : panel_model

/* tb/beacon_local_control_panel_test.sv */
// self-checking bench for the beacon local control panel
`timescale 1ns/100ps
module beacon_local_control_panel_test import panel_pkg::*;;
    // ****************************************
    // signals
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, r, rv;
    logic pready_o, pslverr_o, e;
    logic [N_DB-1:0] pins;
    status_pins_t st = 23'h00_0002;
    logic beacon_on_o, first_transmitter_on_o, second_transmitter_on_o, antenna_second_o, main_is_second_o;
    logic battery_disconnect_o, remote_alarm_o;
    leds_t leds_o;
    int fail_count = 0, n_checks = 0;

    always #2 clk_i = ~clk_i;

    panel_model i_pan (.clk_i(clk_i), .pins_o(pins));
    beacon_local_control_panel #(.DEBOUNCE_CYCLES(4)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .btn_onoff_i(pins[IN_ONOFF]), .active_tx_swap_button_i(pins[IN_SWAP]), .btn_main_sel_i(pins[IN_MAIN_SEL]),
        .remote_sw_i(pins[IN_REMOTE_SW]), .manual_sw_i(pins[IN_MANUAL_SW]), .interlock_i(pins[IN_INTERLOCK]),
        .write_protect_i(pins[IN_WPROT]), .remote_onoff_i(pins[IN_REM_ONOFF]), .remote_swap_i(pins[IN_REM_SWAP]),
        .status_i(st), .beacon_on_o(beacon_on_o), .first_transmitter_on_o(first_transmitter_on_o),
        .second_transmitter_on_o(second_transmitter_on_o), .antenna_second_o(antenna_second_o),
        .main_is_second_o(main_is_second_o), .battery_disconnect_o(battery_disconnect_o),
        .remote_alarm_o(remote_alarm_o), .leds_o(leds_o));

    // ****************************************
    // helpers
    // ****************************************
    task wt(input int k);
        repeat (k) @(posedge clk_i);
    endtask : wt

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; a dead slave is left to the watchdog, idle edge after release
    task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task alarm();
        st.mon1_alarm <= 8'h01;
        wt(8);
        st.mon1_alarm <= 8'h00;
        wt(8);
    endtask : alarm

    function logic [6:0] exp_ind(input status_pins_t s);
        logic a;
        a = |(s.mon1_alarm | s.mon2_alarm);
        return {a, !a, s.rms_warning, s.mon1_warn & s.mon2_warn, s.mon1_alarm != s.mon2_alarm, !s.mains_ok,
            s.maint_fault};
    endfunction : exp_ind

    task test_done();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ****************************************
    // tests
    // ****************************************
    initial begin
        #100000;
        fail_count++;
        test_done();
    end

    initial begin
        r = $urandom(23021);
        wt(8);
        rst_n_i <= 1'b1;
        wt(20);
        bus(0, ADDR_STATUS, 0);
        chk(r[9:0], 10'h000);
        chk(leds_o.service, 1);
        i_pan.press(IN_SWAP);
        chk(antenna_second_o, 0);
        i_pan.press(IN_REM_ONOFF);
        chk(beacon_on_o, 0);
        i_pan.press(IN_ONOFF);
        chk(first_transmitter_on_o, 1);
        i_pan.press(IN_SWAP);
        chk(second_transmitter_on_o, 1);
        i_pan.press(IN_REM_SWAP);
        chk(antenna_second_o, 1);
        i_pan.press(IN_MAIN_SEL);
        chk(main_is_second_o, 1);
        bus(1, ADDR_RMM_MODE, 1);
        chk(e, 1);
        alarm();
        chk(antenna_second_o, 0);
        bus(1, ADDR_CFG, 2);
        alarm();
        chk(beacon_on_o, 0);
        i_pan.press(IN_ONOFF);
        i_pan.set_sw(IN_MANUAL_SW, 1);
        bus(0, ADDR_STATUS, 0);
        chk(r[3], 1);
        alarm();
        chk({beacon_on_o, antenna_second_o}, 2'b10);
        bus(1, ADDR_CFG, 1);
        i_pan.set_sw(IN_INTERLOCK, 1);
        chk(beacon_on_o, 0);
        i_pan.press(IN_ONOFF);
        chk(beacon_on_o, 0);
        i_pan.set_sw(IN_INTERLOCK, 0);
        i_pan.press(IN_ONOFF);
        chk(beacon_on_o, 1);
        i_pan.set_sw(IN_WPROT, 1);
        bus(1, ADDR_LIMIT, 32'h0000_1234);
        chk(e, 1);
        bus(1, ADDR_ACCESS, 32'h0000_000F);
        wt(2);
        bus(0, ADDR_STATUS, 0);
        chk(r[9:6], 4'h2);
        i_pan.set_sw(IN_WPROT, 0);
        bus(1, ADDR_LIMIT, 32'h0000_1234);
        bus(0, ADDR_LIMIT, 0);
        chk(r, 32'h0000_1234);
        i_pan.set_sw(IN_MANUAL_SW, 0);
        i_pan.set_sw(IN_REMOTE_SW, 1);
        bus(1, ADDR_ACCESS, 32'h0000_000A);
        wt(2);
        bus(0, ADDR_STATUS, 0);
        chk(r[9:6], 4'h9);
        chk(leds_o.service, 1);
        bus(1, ADDR_ACCESS, 0);
        wt(4);
        chk(leds_o.service, 0);
        i_pan.press(IN_ONOFF);
        i_pan.press(IN_SWAP);
        chk({beacon_on_o, antenna_second_o}, 2'b10);
        i_pan.press(IN_REM_SWAP);
        chk(antenna_second_o, 1);
        i_pan.press(IN_REM_ONOFF);
        chk(beacon_on_o, 0);
        i_pan.set_sw(IN_MANUAL_SW, 1);
        bus(0, ADDR_STATUS, 0);
        chk({r[3], leds_o.service}, 2'b01);
        i_pan.set_sw(IN_MANUAL_SW, 0);
        bus(1, ADDR_RMM_MODE, 1);
        chk(e, 0);
        wt(2);
        bus(0, ADDR_STATUS, 0);
        chk({r[3], leds_o.service}, 2'b11);
        bus(1, ADDR_RMM_MODE, 0);
        st.wp_strap <= 1'b1;
        wt(6);
        chk(leds_o.service, 1);
        st.wp_strap <= 1'b0;
        st.mains_ok <= 1'b0;
        st.batt_low <= 1'b1;
        wt(6);
        st.batt_low <= 1'b0;
        wt(6);
        chk(battery_disconnect_o, 1);
        st.mains_ok <= 1'b1;
        wt(6);
        chk(battery_disconnect_o, 0);
        // equal monitor sets half the time so disagree sees both outcomes
        for (int i = 0; i < 24; i++) begin
            rv = $urandom;
            st <= {rv[15:8], (rv[16] ? rv[15:8] : rv[7:0]), rv[20:17], 1'b0, rv[21], 1'b0};
            wt(6);
            chk(leds_o[7:1], exp_ind(st));
        end
        bus(0, 12'h020, 0);
        chk(e, 1);
        chk(r, 32'h0000_0000);
        bus(1, ADDR_STATUS, 0);
        chk(e, 1);
        test_done();
    end
endmodule : beacon_local_control_panel_test

bind beacon_local_control_panel panel_asserts i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .status_i(status_i), .beacon_on_o(beacon_on_o),
    .first_transmitter_on_o(first_transmitter_on_o), .second_transmitter_on_o(second_transmitter_on_o),
    .antenna_second_o(antenna_second_o), .main_is_second_o(main_is_second_o),
    .battery_disconnect_o(battery_disconnect_o), .remote_alarm_o(remote_alarm_o), .leds_o(leds_o));
